/* File: hdl/mem_front.v */
// Purpose: SRAM, ROM and flash placement, bit-band alias decode, two-bank SRAM and boot remap.
// Assumes: One master port; code memories (ROM, flash) answer on code_ack_i.
// Notes: SRAM storage is flip-flops; flash programming is not handled here.
`timescale 1ns/1ps
`include "mem_front_map.vh"

// Notes on behaviour
// - SRAM is decoded from 0x2000_0000 upward.
// - Bit-band alias region for SRAM starts at 0x2200_0000.
// - Alias address = base + byte offset * 32 + bit number * 4.
// - Alias access touches one bit only, atomically, no visible read-modify-write.
// - SRAM is two 32-bit banks: even words in one, odd words in other.
// - Write then read of the same bank stalls exactly one cycle.
// - Write then read of the other bank runs in consecutive cycles.
// - ROM is decoded from 0x0100_0000 in the normal map.
// - DMA reaches SRAM only; flash and ROM accesses by DMA are refused.
// - At reset ROM overlays the flash range so first code comes from ROM.
// - First boot step clears the remap: ROM at 0x01xx_xxxx, flash at zero.
// - Pin check enabled (bit clear) and pin matches polarity: ROM at zero, loader runs.
// - Otherwise word at 4 read; if all ones, ROM at zero and loader runs.
// - Otherwise stack pointer from word 0, program counter from word 4, app starts.
// - Boot pin is any pin of ports A to H, selected by boot configuration.
// - ROM holds a two-level function pointer table at 0x0100_0010.
module mem_front (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire req_i,
    input wire we_i,
    input wire dma_i,
    input wire [31:0] addr_i,
    input wire [31:0] wdata_i,
    input wire [3:0] be_i,
    input wire [7:0] boot_select_config_i,
    input wire [63:0] gpio_i,
    input wire code_ack_i,
    input wire [31:0] code_rdata_i,
    output reg busy_o,
    output reg ack_o,
    output reg err_o,
    output reg [31:0] rdata_o,
    output reg code_req_o,
    output reg code_rom_sel_o,
    output reg [23:0] code_addr_o,
    output reg boot_done_o,
    output reg loader_run_o,
    output reg rom_at_zero_o,
    output reg [31:0] stack_pointer_o,
    output reg [31:0] program_counter_o,
    output reg [31:0] api_table_o
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    // Boot sequencer states
    localparam [2:0] BT_OVL = 3'h0;
    localparam [2:0] BT_CLR = 3'h1;
    localparam [2:0] BT_PIN = 3'h2;
    localparam [2:0] BT_RD4 = 3'h3;
    localparam [2:0] BT_RD0 = 3'h4;
    localparam [2:0] BT_RUN = 3'h5;
    // Bus service states
    localparam [1:0] BS_IDLE = 2'h0;
    localparam [1:0] BS_STALL = 2'h1;
    localparam [1:0] BS_CODE = 2'h2;

    // Each bank holds 4096 words, 32 KB across both
    reg [31:0] even_mem [0:4095];
    reg [31:0] odd_mem [0:4095];
    reg [63:0] gpio_s1_ff, gpio_s2_ff, gpio_s3_ff, gpio_ff;
    reg [1:0] settle_ff;
    reg [2:0] bt_ff;
    reg [1:0] bs_ff;
    reg code_wait_ff;
    reg [31:0] pc_word_ff;
    // Write history for the bank conflict check
    reg lastw_v_ff;
    reg lastw_bank_ff;
    // Captured fields of a stalled read
    reg h_we_ff, h_dma_ff;
    reg [31:0] h_addr_ff, h_wdata_ff;
    reg [3:0] h_be_ff;

    // ----------------------------------------
    // Select the request being served
    // ----------------------------------------
    // A held request replays the captured fields so the master may move on.
    wire take = req_i & ~busy_o & (bs_ff == BS_IDLE);
    wire held = (bs_ff == BS_STALL);
    wire exec = take | held;
    wire c_we = held ? h_we_ff : we_i;
    wire c_dma = held ? h_dma_ff : dma_i;
    wire [31:0] c_addr = held ? h_addr_ff : addr_i;
    wire [31:0] c_wdata = held ? h_wdata_ff : wdata_i;
    wire [3:0] c_be = held ? h_be_ff : be_i;

    // ----------------------------------------
    // Region decode
    // ----------------------------------------
    // Shifting both sides keeps each compare 32 bits wide; only the upper bits decide
    wire is_sram = (c_addr >> `SRAM_TOP_LSB) == (`SRAM_BASE >> `SRAM_TOP_LSB);
    wire is_alias = (c_addr >> `ALIAS_TOP_LSB) == (`ALIAS_BASE >> `ALIAS_TOP_LSB);
    wire is_flash = (c_addr >> `CODE_TOP_LSB) == (`FLASH_BASE >> `CODE_TOP_LSB);
    wire is_rom = (c_addr >> `CODE_TOP_LSB) == (`ROM_BASE >> `CODE_TOP_LSB);
    wire is_ram = is_sram | is_alias;
    wire is_code = is_flash | is_rom;

    // Alias offset splits into byte offset (times 32) and bit number (times 4)
    wire [14:0] a_byte = c_addr[`ALIAS_BYTE_SHIFT+14:`ALIAS_BYTE_SHIFT];
    wire [2:0] a_bit = c_addr[`ALIAS_BIT_SHIFT+2:`ALIAS_BIT_SHIFT];
    wire [4:0] a_pos = {a_byte[1:0], a_bit};
    wire [12:0] word = is_alias ? a_byte[14:2] : c_addr[14:2];
    wire bank = word[0];
    wire [11:0] widx = word[12:1];
    // Unclocked read of the addressed word feeds both read data and the merge
    wire [31:0] old_word = bank ? odd_mem[widx] : even_mem[widx];

    // ----------------------------------------
    // Bank conflict check
    // ----------------------------------------
    // Only a read directly after a write to the same bank waits; the stall
    // cycle itself clears the write history so it never stretches past one.
    wire stall = take & is_ram & ~c_we & lastw_v_ff & (lastw_bank_ff == bank);
    wire ram_go = exec & is_ram & ~stall;
    wire ram_wr = ram_go & c_we;

    // ----------------------------------------
    // Write data merge
    // ----------------------------------------
    // Alias writes change one bit inside the same cycle, so no other master
    // can observe a partial read-modify-write.
    reg [31:0] new_word;
    integer k;
    always @* begin
        new_word = old_word;
        if (is_alias) begin
            new_word[a_pos] = c_wdata[0];
        end else begin
            for (k = 0; k < 4; k = k + 1) begin
                if (c_be[k]) begin
                    new_word[k*8 +: 8] = c_wdata[k*8 +: 8];
                end
            end
        end
    end

    // ----------------------------------------
    // SRAM banks
    // ----------------------------------------
    // Storage has no reset; contents are undefined until written.
    always @(posedge sys_clk_i) begin
        if (ram_wr && !bank) begin
            even_mem[widx] <= new_word;
        end
        if (ram_wr && bank) begin
            odd_mem[widx] <= new_word;
        end
    end

    // ----------------------------------------
    // Boot pin synchroniser
    // ----------------------------------------
    // A pin level counts only once the second and third stages agree.
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gpio_s1_ff <= 64'h0;
            gpio_s2_ff <= 64'h0;
            gpio_s3_ff <= 64'h0;
            gpio_ff <= 64'h0;
        end else begin
            gpio_s1_ff <= gpio_i;
            gpio_s2_ff <= gpio_s1_ff;
            gpio_s3_ff <= gpio_s2_ff;
            gpio_ff <= (gpio_s2_ff & gpio_s3_ff) | (gpio_ff & (gpio_s2_ff ^ gpio_s3_ff));
        end
    end

    // Port in the upper three bits, pin in the lower three: any pin of ports A to H
    wire [5:0] pin_sel = {boot_select_config_i[`CFG_PORT_LSB+2:`CFG_PORT_LSB],
                          boot_select_config_i[`CFG_PIN_LSB+2:`CFG_PIN_LSB]};
    wire pin_match = gpio_ff[pin_sel] == boot_select_config_i[`CFG_POL_BIT];
    wire pin_check = ~boot_select_config_i[`CFG_EN_BIT];

    // ----------------------------------------
    // Boot sequencer and bus control
    // ----------------------------------------
    // Both share the code port; the bus stays busy until boot finishes,
    // so the two never issue in the same cycle.
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bt_ff <= BT_OVL;
            bs_ff <= BS_IDLE;
            settle_ff <= 2'h0;
            code_wait_ff <= 1'b0;
            pc_word_ff <= `RST_WORD;
            lastw_v_ff <= 1'b0;
            lastw_bank_ff <= 1'b0;
            h_we_ff <= 1'b0;
            h_dma_ff <= 1'b0;
            h_addr_ff <= `RST_WORD;
            h_wdata_ff <= `RST_WORD;
            h_be_ff <= 4'h0;
            busy_o <= 1'b1;
            ack_o <= 1'b0;
            err_o <= 1'b0;
            rdata_o <= `RST_WORD;
            code_req_o <= 1'b0;
            code_rom_sel_o <= 1'b1;
            code_addr_o <= 24'h0;
            boot_done_o <= 1'b0;
            loader_run_o <= 1'b0;
            rom_at_zero_o <= 1'b1;
            stack_pointer_o <= `RST_WORD;
            program_counter_o <= `RST_WORD;
            api_table_o <= `API_TABLE_ADDR;
        end else begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            code_req_o <= 1'b0;
            // Remember whether this cycle wrote SRAM, and which bank
            lastw_v_ff <= ram_wr;
            if (ram_wr) begin
                lastw_bank_ff <= bank;
            end
            // Boot sequence after reset
            case (bt_ff)
                BT_OVL: begin
                    // Overlay holds while the pin synchroniser fills
                    if (settle_ff == `SYNC_SETTLE) begin
                        bt_ff <= BT_CLR;
                    end else begin
                        settle_ff <= settle_ff + 2'h1;
                    end
                end
                BT_CLR: begin
                    // Flash at zero, ROM back at its normal place
                    rom_at_zero_o <= 1'b0;
                    bt_ff <= BT_PIN;
                end
                BT_PIN: begin
                    // Pin check applies only while its disable bit is clear
                    if (pin_check && pin_match) begin
                        rom_at_zero_o <= 1'b1;
                        loader_run_o <= 1'b1;
                        bt_ff <= BT_RUN;
                    end else begin
                        code_req_o <= 1'b1;
                        code_rom_sel_o <= 1'b0;
                        code_addr_o <= `VEC_PC_ADDR;
                        code_wait_ff <= 1'b1;
                        bt_ff <= BT_RD4;
                    end
                end
                BT_RD4: begin
                    // Answers count only while a vector read is outstanding
                    if (code_wait_ff && code_ack_i) begin
                        code_wait_ff <= 1'b0;
                        if (code_rdata_i == `ERASED_WORD) begin
                            rom_at_zero_o <= 1'b1;
                            loader_run_o <= 1'b1;
                            bt_ff <= BT_RUN;
                        end else begin
                            pc_word_ff <= code_rdata_i;
                            code_req_o <= 1'b1;
                            code_addr_o <= `VEC_SP_ADDR;
                            code_wait_ff <= 1'b1;
                            bt_ff <= BT_RD0;
                        end
                    end
                end
                BT_RD0: begin
                    if (code_wait_ff && code_ack_i) begin
                        code_wait_ff <= 1'b0;
                        stack_pointer_o <= code_rdata_i;
                        program_counter_o <= pc_word_ff;
                        bt_ff <= BT_RUN;
                    end
                end
                BT_RUN: begin
                    // Bus opens one cycle after the memory map is final
                    if (!boot_done_o) begin
                        boot_done_o <= 1'b1;
                        busy_o <= 1'b0;
                    end
                end
                default: begin
                    bt_ff <= BT_OVL;
                end
            endcase
            // Bus requests are served only once boot has finished
            if (boot_done_o) begin
                case (bs_ff)
                    BS_IDLE, BS_STALL: begin
                        if (stall) begin
                            // Capture the read and serve it next cycle
                            h_we_ff <= we_i;
                            h_dma_ff <= dma_i;
                            h_addr_ff <= addr_i;
                            h_wdata_ff <= wdata_i;
                            h_be_ff <= be_i;
                            bs_ff <= BS_STALL;
                            busy_o <= 1'b1;
                        end else if (exec && is_ram) begin
                            ack_o <= 1'b1;
                            bs_ff <= BS_IDLE;
                            busy_o <= 1'b0;
                            if (is_alias) begin
                                rdata_o <= {31'h0, old_word[a_pos]};
                            end else begin
                                rdata_o <= old_word;
                            end
                        end else if (exec && is_code && !c_dma && !c_we) begin
                            code_req_o <= 1'b1;
                            code_rom_sel_o <= is_rom | rom_at_zero_o;
                            code_addr_o <= c_addr[23:0];
                            bs_ff <= BS_CODE;
                            busy_o <= 1'b1;
                        end else if (exec) begin
                            // DMA to code memories, code writes and holes fail
                            ack_o <= 1'b1;
                            err_o <= 1'b1;
                            rdata_o <= `RST_WORD;
                            bs_ff <= BS_IDLE;
                            busy_o <= 1'b0;
                        end
                    end
                    BS_CODE: begin
                        // Code memories answer after a variable delay; the bus stays busy
                        if (code_ack_i) begin
                            ack_o <= 1'b1;
                            rdata_o <= code_rdata_i;
                            bs_ff <= BS_IDLE;
                            busy_o <= 1'b0;
                        end
                    end
                    default: begin
                        bs_ff <= BS_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* File: hdl/mem_front_map.vh */
// Purpose: Address map, field positions and reset values of the on-chip memory front end.
// Assumes: Included by hdl/mem_front.v only; definitions only.
// Notes: Boot configuration field layout is a local choice.
`ifndef MEM_FRONT_MAP_VH
`define MEM_FRONT_MAP_VH

// ----------------------------------------
// Region bases
// ----------------------------------------
`define SRAM_BASE 32'h2000_0000
`define ALIAS_BASE 32'h2200_0000
`define ROM_BASE 32'h0100_0000
`define FLASH_BASE 32'h0000_0000
`define API_TABLE_ADDR 32'h0100_0010

// ----------------------------------------
// Region decode widths (upper address bits compared)
// ----------------------------------------
`define CODE_TOP_LSB 24
`define SRAM_TOP_LSB 15
`define ALIAS_TOP_LSB 20

// ----------------------------------------
// Bit-band alias: byte offset times 32, bit number times 4
// ----------------------------------------
`define ALIAS_BYTE_SHIFT 5
`define ALIAS_BIT_SHIFT 2

// ----------------------------------------
// Boot vectors and erased value
// ----------------------------------------
`define VEC_SP_ADDR 24'h00_0000
`define VEC_PC_ADDR 24'h00_0004
`define ERASED_WORD 32'hffff_ffff

// ----------------------------------------
// Boot configuration fields
// ----------------------------------------
`define CFG_EN_BIT 0
`define CFG_POL_BIT 1
`define CFG_PIN_LSB 2
`define CFG_PORT_LSB 5

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SYNC_SETTLE 2'h3
`define RST_WORD 32'h0000_0000

`endif

/* File: tb/code_mem_model.sv */
// Purpose: ROM and flash behind the code port.
// Assumes: One outstanding read; wait_i sets the answer delay.
// Notes: Data toggles while idle so stale data never matches.
`timescale 1ns/1ps
module code_mem_model (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire code_req_i,
    input wire code_rom_sel_i,
    input wire [23:0] code_addr_i,
    input wire [1:0] wait_i,
    input wire [31:0] sp_word_i,
    input wire [31:0] pc_word_i,
    output reg code_ack_o,
    output reg [31:0] code_rdata_o
);
    reg pend_ff;
    reg sel_ff;
    reg [23:0] adr_ff;
    reg [1:0] cnt_ff;
    // Vector words at flash 0 and 4, address pattern elsewhere
    function [31:0] word(input s, input [23:0] a);
        word = s ? {8'h01, a} : a == 24'h4 ? pc_word_i : a == 24'h0 ? sp_word_i : {8'h00, a};
    endfunction
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {pend_ff, sel_ff, adr_ff, cnt_ff, code_ack_o} <= 29'h0;
            code_rdata_o <= 32'h0;
        end else begin
            code_ack_o <= 1'b0;
            code_rdata_o <= ~code_rdata_o;
            if (code_req_i) begin
                {pend_ff, sel_ff, adr_ff, cnt_ff} <= {1'b1, code_rom_sel_i, code_addr_i, wait_i};
            end else if (pend_ff && cnt_ff != 2'h0) begin
                cnt_ff <= cnt_ff - 2'h1;
            end else if (pend_ff) begin
                pend_ff <= 1'b0;
                code_ack_o <= 1'b1;
                code_rdata_o <= word(sel_ff, adr_ff);
            end
        end
    end
endmodule

/* File: tb/mem_front_assertions.sv */
// Purpose: Port-level temporal checks of the memory front end.
// Assumes: One clock; nrst_i asynchronous, active low.
// Notes: SRAM is 32 KB at 0x2000_0000, alias 1 MB at 0x2200_0000.
`timescale 1ns/1ps
module mem_front_chk (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire req_i,
    input wire we_i,
    input wire dma_i,
    input wire [31:0] addr_i,
    input wire code_ack_i,
    input wire [31:0] code_rdata_i,
    input wire busy_o,
    input wire ack_o,
    input wire err_o,
    input wire [31:0] rdata_o,
    input wire code_req_o,
    input wire code_rom_sel_o,
    input wire [23:0] code_addr_o,
    input wire boot_done_o,
    input wire loader_run_o,
    input wire rom_at_zero_o,
    input wire [31:0] api_table_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // --------------------------------
    // Decode helpers
    // --------------------------------
    wire tk = req_i && !busy_o;
    wire sram = addr_i[31:15] == 17'h04000;
    wire [23:0] off = addr_i[23:0];
    sequence wr_s;
        tk && we_i && sram;
    endsequence
    // Read of the bank written one cycle earlier
    sequence rd_same_s;
        tk && !we_i && sram && addr_i[2] == $past(addr_i[2]);
    endsequence
    sequence rd_other_s;
        tk && !we_i && sram && addr_i[2] != $past(addr_i[2]);
    endsequence
    // --------------------------------
    // Checks
    // --------------------------------
    sram_wr_ack_a: assert property (wr_s |=> ack_o && !err_o)
        else $error("sram write not answered");
    same_bank_a: assert property (wr_s ##1 rd_same_s |=> busy_o && !ack_o ##1 ack_o)
        else $error("same bank stall wrong");
    other_bank_a: assert property (wr_s ##1 rd_other_s |=> ack_o)
        else $error("other bank read delayed");
    alias_read_a: assert property (tk && !we_i && addr_i[31:20] == 12'h220
        |-> ##[1:2] ack_o ##0 rdata_o[31:1] == 31'h0) else $error("alias read not one bit");
    dma_code_a: assert property (tk && dma_i && addr_i[31:25] == 7'h0 |=> ack_o && err_o)
        else $error("dma reached code space");
    rom_read_a: assert property (tk && !dma_i && !we_i && addr_i[31:24] == 8'h01
        |=> code_req_o && code_rom_sel_o && code_addr_o == $past(off)) else $error("rom decode wrong");
    code_ret_a: assert property (code_ack_i && boot_done_o |=> ack_o && rdata_o == $past(code_rdata_i))
        else $error("code data not returned");
    boot_flash_a: assert property (code_req_o && !boot_done_o |-> !code_rom_sel_o && !rom_at_zero_o)
        else $error("boot read not from flash");
    boot_busy_a: assert property (!boot_done_o |-> busy_o)
        else $error("bus open during boot");
    boot_map_a: assert property ($rose(boot_done_o) |-> rom_at_zero_o == loader_run_o)
        else $error("boot map mismatch");
    api_ptr_a: assert property (api_table_o == 32'h0100_0010)
        else $error("api table pointer wrong");
endmodule
bind mem_front mem_front_chk i_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i), .we_i(we_i),
    .dma_i(dma_i), .addr_i(addr_i), .code_ack_i(code_ack_i), .code_rdata_i(code_rdata_i), .busy_o(busy_o),
    .ack_o(ack_o), .err_o(err_o), .rdata_o(rdata_o), .code_req_o(code_req_o), .code_rom_sel_o(code_rom_sel_o),
    .code_addr_o(code_addr_o), .boot_done_o(boot_done_o), .loader_run_o(loader_run_o),
    .rom_at_zero_o(rom_at_zero_o), .api_table_o(api_table_o));

/* File: tb/testbench.sv */
// Purpose: Self-checking bench of the memory front end.
// Assumes: Inputs change at the falling edge.
// Notes: Random stimulus from a fixed seed.
`timescale 1ns/1ps
module testbench;
    logic sys_clk_i, nrst_i, req_i, we_i, dma_i, code_ack_i, busy_o, ack_o, err_o, code_req_o, sel, done, ldr, r0;
    logic [31:0] addr_i, wdata_i, code_rdata_i, rdata_o, sp_o, pc_o, api_o, rd, sp_w, pc_w, d, e;
    logic [3:0] be_i;
    logic [7:0] cfg;
    logic [63:0] gpio_i;
    logic [1:0] wt;
    logic [23:0] caddr;
    logic er;
    int error_cnt = 0, compares = 0, seed = 32'h7576, cyc = 0, w, b;
    mem_front i_mem_front (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i), .we_i(we_i), .dma_i(dma_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .be_i(be_i), .boot_select_config_i(cfg), .gpio_i(gpio_i),
        .code_ack_i(code_ack_i), .code_rdata_i(code_rdata_i), .busy_o(busy_o), .ack_o(ack_o), .err_o(err_o),
        .rdata_o(rdata_o), .code_req_o(code_req_o), .code_rom_sel_o(sel), .code_addr_o(caddr),
        .boot_done_o(done), .loader_run_o(ldr), .rom_at_zero_o(r0), .stack_pointer_o(sp_o),
        .program_counter_o(pc_o), .api_table_o(api_o));
    code_mem_model i_code_mem_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .code_req_i(code_req_o),
        .code_rom_sel_i(sel), .code_addr_i(caddr), .wait_i(wt), .sp_word_i(sp_w), .pc_word_i(pc_w),
        .code_ack_o(code_ack_i), .code_rdata_o(code_rdata_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // Answer delay of the code memories varies, cycle count guards a hang
    always @(negedge sys_clk_i) wt <= 2'($random(seed));
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            $display("Error cycles expected below %0d seen %0d", 20000, cyc);
            error_cnt++;
            end_sim();
        end
    end
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (x !== g) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task ck1(input string n, input logic x, input logic g);
        chk(n, {31'h0, x}, {31'h0, g});
    endtask
    // One request, held for one cycle, then a bounded wait for the answer
    task bus(input logic wr, input logic dm, input logic [31:0] a, input logic [31:0] wd, input logic [3:0] be);
        int n;
        {req_i, we_i, dma_i, addr_i, wdata_i, be_i} = {1'b1, wr, dm, a, wd, be};
        @(negedge sys_clk_i);
        req_i = 1'b0;
        for (n = 0; ack_o !== 1'b1 && n < 50; n++) @(negedge sys_clk_i);
        ck1("ack", 1'b1, ack_o);
        {rd, er} = {rdata_o, err_o};
        @(negedge sys_clk_i);
    endtask
    task boot(input logic [7:0] c, input logic [63:0] g, input logic [31:0] s, input logic [31:0] p, input logic l);
        int n;
        {nrst_i, cfg, gpio_i, sp_w, pc_w} = {1'b0, c, g, s, p};
        repeat (10) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        for (n = 0; done !== 1'b1 && n < 100; n++) @(negedge sys_clk_i);
        ck1("boot_done", 1'b1, done);
        ck1("loader", l, ldr);
        ck1("rom_at_zero", l, r0);
        if (!l) chk("sp", s, sp_o);
        if (!l) chk("pc", p, pc_o);
        $display("test boot %0d end", l);
    endtask
    // Write then read in the next cycle; stall expected only on the same bank
    task b2b(input int wa, input int ra, input logic [31:0] x, input logic st);
        {req_i, we_i, dma_i, be_i, addr_i, wdata_i} = {3'b110, 4'hf, 32'h2000_0000 + wa * 4, 32'($random(seed))};
        @(negedge sys_clk_i);
        {we_i, addr_i} = {1'b0, 32'h2000_0000 + ra * 4};
        ck1("write_ack", 1'b1, ack_o);
        @(negedge sys_clk_i);
        req_i = 1'b0;
        if (st) ck1("stall", 1'b1, busy_o & !ack_o);
        if (st) @(negedge sys_clk_i);
        ck1("read_ack", 1'b1, ack_o);
        chk("read_data", x, rdata_o);
        @(negedge sys_clk_i);
    endtask
    // Expected word after a byte-enabled write
    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
        be_merge = o;
        for (int k = 0; k < 4; k++) if (m[k]) be_merge[k*8 +: 8] = n[k*8 +: 8];
    endfunction
    // Alias address of one SRAM bit: base, byte offset times 32, bit number times 4
    function automatic logic [31:0] alias_adr(input int ofs, input int bn);
        alias_adr = 32'h2200_0000 + 32'(ofs * 32 + bn * 4);
    endfunction
    task end_sim();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {req_i, we_i, dma_i, addr_i, wdata_i, be_i} = 0;
        b = {$random(seed)} % 64;
        boot({b[5:0], 2'b10}, 64'h1 << b, 32'h0, 32'h0, 1'b1);
        boot(8'h01, 64'h0, 32'h0, 32'hffff_ffff, 1'b1);
        {d, e} = {32'($random(seed)), 32'($random(seed)) & 32'h7fff_fffe};
        boot({b[5:0], 2'b00}, 64'h1 << b, d, e, 1'b0);
        bus(1'b0, 1'b0, 32'h0, 32'h0, 4'h0);
        chk("flash_zero", d, rd);
        w = {$random(seed)} % 4096;
        bus(1'b0, 1'b0, 32'h0100_0000 + w * 4, 32'h0, 4'h0);
        chk("rom", {8'h01, 24'(w * 4)}, rd);
        chk("api", 32'h0100_0010, api_o);
        for (int i = 0; i < 4; i++) begin
            bus(i == 2, i < 2, i[0] ? 32'h0100_0000 : (i == 2 ? 32'h0100_0040 : 32'h0000_0100), 32'h0, 4'hf);
            if (i == 3) bus(1'b0, 1'b0, 32'h3000_0000, 32'h0, 4'h0);
            ck1("refused", 1'b1, er);
            chk("refused_data", 32'h0, rd);
        end
        bus(1'b1, 1'b1, 32'h2000_0010, 32'h1234_5678, 4'hf);
        bus(1'b0, 1'b1, 32'h2000_0010, 32'h0, 4'h0);
        chk("dma_sram", 32'h1234_5678, rd);
        $display("test code end");
        for (int i = 0; i < 16; i++) begin
            {w, d, e, be_i} = {{$random(seed)} % 8192, 32'($random(seed)), 32'($random(seed)), 4'($random(seed))};
            b = be_i;
            bus(1'b1, 1'b0, 32'h2000_0000 + w * 4, d, 4'hf);
            bus(1'b1, 1'b0, 32'h2000_0000 + w * 4, e, 4'(b));
            d = be_merge(d, e, 4'(b));
            bus(1'b0, 1'b0, 32'h2000_0000 + w * 4, 32'h0, 4'h0);
            chk("sram", d, rd);
            bus(1'b1, 1'b0, 32'h2000_0000 + (w ^ (i % 2 + 1)) * 4, e, 4'hf);
            b2b(w, w ^ (i % 2 + 1), e, i[0]);
        end
        $display("test sram end");
        for (int i = 0; i < 10; i++) begin
            w = i == 0 ? 0 : (i == 1 ? 32767 : {$random(seed)} % 32768);
            {b, d, e} = {{$random(seed)} % 8, 32'($random(seed)), 32'($random(seed))};
            bus(1'b1, 1'b0, 32'h2000_0000 + (w / 4) * 4, d, 4'hf);
            bus(1'b1, 1'b0, alias_adr(w, b), e, 4'h0);
            d[(w % 4) * 8 + b] = e[0];
            bus(1'b0, 1'b0, alias_adr(w, b), 32'h0, 4'h0);
            chk("alias_read", {31'h0, e[0]}, rd);
            bus(1'b0, 1'b0, 32'h2000_0000 + (w / 4) * 4, 32'h0, 4'h0);
            chk("alias_word", d, rd);
        end
        $display("test alias end");
        end_sim();
    end
endmodule
